// file: core/sbs_burst_count.sv
// Purpose: two-bit burst address counter, linear or interleaved
// Assumes: load and advance never together
// Notes:   step wraps so the fifth address equals the first
`default_nettype none

module sbs_burst_count
	import sbs_pkg::*;
#(
	parameter int BW = BURST_W
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_b,
	// control
	input  wire logic          load,
	input  wire logic          advance,
	input  wire logic          linear,
	input  wire logic [BW-1:0] start,
	// results
	output logic      [BW-1:0] cur_low,
	output logic      [BW-1:0] next_low,
	output logic      [BW-1:0] step
);

	logic [BW-1:0] start_q;
	logic [BW-1:0] next_start;
	logic [BW-1:0] next_step;
	logic [BW-1:0] step_inc;

	// low address bits from start and step
	function automatic logic [BW-1:0] burst_low(input logic lin, input logic [BW-1:0] s,
			input logic [BW-1:0] k);
		burst_low = lin ? BW'(s + k) : (s ^ k);
	endfunction : burst_low

	// next values of start and step
	always_comb begin
		step_inc   = BW'(step + STEP_ONE); // wraps after the fourth
		next_start = start_q;
		next_step  = step;
		if (load) begin
			next_start = start;
			next_step  = STEP_ZERO;
		end else if (advance) begin
			next_step = step_inc;
		end
		cur_low  = burst_low(linear, start_q, step);
		next_low = burst_low(linear, start_q, step_inc);
	end

	// counter registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			start_q <= STEP_ZERO;
			step    <= STEP_ZERO;
		end else begin
			start_q <= next_start;
			step    <= next_step;
		end
	end

endmodule : sbs_burst_count

`default_nettype wire

// file: core/sbs_lane_decode.sv
// Purpose: byte-lane write decode from global and lane strobes
// Assumes: all strobes active low, same clock domain
// Notes:   purely combinational
`default_nettype none

module sbs_lane_decode
	import sbs_pkg::*;
(
	// write strobes
	input  wire logic             global_store_n,
	input  wire logic             byte_lane_gate_n,
	input  wire logic [LANES-1:0] lane_store_n,
	// decoded
	output logic      [LANES-1:0] lane_we,
	output logic                  store_intent
);

	// one enable per lane
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		assign lane_we[g] = !global_store_n || (!byte_lane_gate_n && !lane_store_n[g]);
	end

	// any lane written makes it a write cycle
	assign store_intent = |lane_we;

endmodule : sbs_lane_decode

`default_nettype wire

// file: core/sbs_pkg.sv
// Purpose: shared constants and types of the burst sram control block
// Assumes: one clock, 32-bit data in four byte lanes
// Notes:   register offsets are byte addresses on the axi4-lite slave
`default_nettype none

package sbs_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W_DEF = 16;
	localparam int LANES      = 4;
	localparam int LANE_W     = 8;
	localparam int DATA_W     = LANES * LANE_W;
	localparam int BURST_W    = 2;
	localparam int AXI_AW     = 4;

	// ------------------------------------------------------------
	// burst counter constants
	// ------------------------------------------------------------
	localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
	localparam logic [BURST_W-1:0] STEP_ONE  = 2'h1;
	localparam logic [BURST_W-1:0] STEP_LAST = 2'h3;

	// ------------------------------------------------------------
	// mode pins: raw levels while reset holds (pull defaults)
	// ------------------------------------------------------------
	localparam logic ORDER_PIN_RESET  = 1'b1;
	localparam logic BYPASS_PIN_RESET = 1'b1;
	localparam logic SLEEP_PIN_RESET  = 1'b0;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [AXI_AW-1:0] REG_CTRL   = 4'h0;
	localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
	localparam logic [AXI_AW-1:0] REG_ADDR   = 4'h8;
	localparam int CTRL_SLEEP_BIT  = 0;
	localparam int STAT_LOW_LSB    = 0;
	localparam int STAT_SLEEP_BIT  = 2;
	localparam int STAT_FLOW_BIT   = 3;
	localparam int STAT_LINEAR_BIT = 4;
	localparam int STAT_DRIVE_BIT  = 5;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {OP_DESEL, OP_READ, OP_WRITE} sbs_op_t;
	typedef enum logic [1:0] {SRC_NONE, SRC_EXT, SRC_NEXT, SRC_CUR} sbs_src_t;

	typedef struct packed {
		sbs_op_t  op;
		sbs_src_t src;
	} sbs_cyc_t;

	typedef struct packed {
		logic linear;
		logic flow;
		logic sleep;
	} sbs_mode_t;

endpackage : sbs_pkg

`default_nettype wire

// file: core/sbs_sram_core.sv
// Purpose: synchronous burst sram: command decode, burst, array, data drive
// Assumes: host drives strobes, address and data on clk, same domain
// Notes:   mode pins are asynchronous and pass two flops first
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none

module sbs_sram_core
	import sbs_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_DEF
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// mode pins
	input  wire logic              burst_order_select,
	input  wire logic              output_bypass_select,
	input  wire logic              sleep_request,
	// selects and strobes
	input  wire logic              chip_select_primary_n,
	input  wire logic              select_high_active,
	input  wire logic              select_low_third_n,
	input  wire logic              proc_addr_strobe_n,
	input  wire logic              ctrl_addr_strobe_n,
	input  wire logic              burst_step_n,
	// write strobes
	input  wire logic              global_store_n,
	input  wire logic              byte_lane_gate_n,
	input  wire logic              lane_a_store_n,
	input  wire logic              lane_b_store_n,
	input  wire logic              lane_c_store_n,
	input  wire logic              lane_d_store_n,
	input  wire logic              output_enable_n,
	// address
	input  wire logic [ADDR_W-3:0] addr_high,
	input  wire logic [1:0]        low_addr_bits,
	// data pins
	input  wire logic [DATA_W-1:0] dq_in,
	output logic      [DATA_W-1:0] dq_out,
	output logic      [LANES-1:0]  dq_oe,
	// axi4-lite slave
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [LANES-1:0]  s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [DATA_W-1:0] s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	localparam int HI_W  = ADDR_W - BURST_W;
	localparam int DEPTH = 1 << ADDR_W;

	// ------------------------------------------------------------
	// mode pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] mode_meta;
	logic [2:0] mode_raw;
	sbs_mode_t  mode;
	logic       ctrl_sleep;
	logic       sleep_active;

	// two flops per asynchronous mode pin
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_meta <= {ORDER_PIN_RESET, BYPASS_PIN_RESET, SLEEP_PIN_RESET};
			mode_raw  <= {ORDER_PIN_RESET, BYPASS_PIN_RESET, SLEEP_PIN_RESET};
		end else begin
			mode_meta <= {burst_order_select, output_bypass_select, sleep_request};
			mode_raw  <= mode_meta;
		end
	end

	// low picks linear and flow, high picks sleep
	always_comb begin
		mode.linear  = !mode_raw[2];
		mode.flow    = !mode_raw[1];
		mode.sleep   = mode_raw[0];
		sleep_active = mode.sleep || ctrl_sleep;
	end

	// ------------------------------------------------------------
	// cycle decode
	// ------------------------------------------------------------
	logic [LANES-1:0] lane_we;
	logic             store_intent;
	logic             enable_all;
	sbs_cyc_t         cyc;
	sbs_op_t          rw_op;

	sbs_lane_decode u_lane (
		.global_store_n   (global_store_n),
		.byte_lane_gate_n (byte_lane_gate_n),
		.lane_store_n     ({lane_d_store_n, lane_c_store_n, lane_b_store_n, lane_a_store_n}),
		.lane_we          (lane_we),
		.store_intent     (store_intent)
	);

	// synchronous truth table, first match wins
	always_comb begin
		enable_all = select_high_active && !select_low_third_n;
		rw_op      = store_intent ? OP_WRITE : OP_READ;
		cyc.op     = OP_DESEL;
		cyc.src    = SRC_NONE;
		if (sleep_active) begin
			cyc.op = OP_DESEL; // array untouched while asleep
		end else if (chip_select_primary_n && !ctrl_addr_strobe_n) begin
			cyc.op = OP_DESEL;
		end else if (!chip_select_primary_n && !enable_all &&
				(!proc_addr_strobe_n || !ctrl_addr_strobe_n)) begin
			cyc.op = OP_DESEL;
		end else if (!chip_select_primary_n && !proc_addr_strobe_n) begin
			cyc.op  = OP_READ;
			cyc.src = SRC_EXT;
		end else if (!chip_select_primary_n && !ctrl_addr_strobe_n) begin
			cyc.op  = rw_op;
			cyc.src = SRC_EXT;
		end else if (!burst_step_n) begin
			cyc.op  = rw_op;
			cyc.src = SRC_NEXT;
		end else begin
			cyc.op  = rw_op;
			cyc.src = SRC_CUR;
		end
	end

	// ------------------------------------------------------------
	// burst address
	// ------------------------------------------------------------
	logic [HI_W-1:0]    addr_hi;
	logic [HI_W-1:0]    next_addr_hi;
	logic [BURST_W-1:0] burst_low;
	logic [BURST_W-1:0] burst_next;
	logic [BURST_W-1:0] burst_step;
	logic [ADDR_W-1:0]  addr_used;

	// counter advances on any next cycle, dummy reads too
	sbs_burst_count #(.BW(BURST_W)) u_count (
		.clk      (clk),
		.rst_b    (rst_b),
		.load     (cyc.src == SRC_EXT),
		.advance  (cyc.src == SRC_NEXT),
		.linear   (mode.linear),
		.start    (low_addr_bits),
		.cur_low  (burst_low),
		.next_low (burst_next),
		.step     (burst_step)
	);

	// address this cycle uses
	always_comb begin
		next_addr_hi = addr_hi;
		addr_used    = {addr_hi, burst_low};
		case (cyc.src)
			SRC_EXT: begin
				next_addr_hi = addr_high;
				addr_used    = {addr_high, low_addr_bits};
			end
			SRC_NEXT: addr_used = {addr_hi, burst_next};
			default:  addr_used = {addr_hi, burst_low};
		endcase
	end

	// ------------------------------------------------------------
	// array, no reset so contents survive
	// ------------------------------------------------------------
	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] mem_rd;

	assign mem_rd = mem[addr_used];

	// lane-masked write on a write cycle, one process so the array has one driver
	always_ff @(posedge clk) begin
		for (int g = 0; g < LANES; g++) begin
			if (cyc.op == OP_WRITE && lane_we[g]) begin
				mem[addr_used][g*LANE_W +: LANE_W] <= dq_in[g*LANE_W +: LANE_W];
			end
		end
	end

	// ------------------------------------------------------------
	// read path and drivers
	// ------------------------------------------------------------
	logic [DATA_W-1:0] pipe_data;
	logic [DATA_W-1:0] next_dq_out;
	logic              rd_q;
	logic              drive_q;
	logic              next_drive;

	// flow shows this read now, pipeline shows last read
	always_comb begin
		next_dq_out = mode.flow ? mem_rd : pipe_data;
		case (cyc.op)
			OP_READ:  next_drive = mode.flow || rd_q;
			OP_WRITE: next_drive = 1'b0;
			default:  next_drive = 1'b0; // off at once
		endcase
	end

	// data and drive registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pipe_data <= '0;
			dq_out    <= '0;
			rd_q      <= 1'b0;
			drive_q   <= 1'b0;
			addr_hi   <= '0;
		end else begin
			pipe_data <= mem_rd;
			dq_out    <= next_dq_out;
			rd_q      <= (cyc.op == OP_READ);
			drive_q   <= next_drive;
			addr_hi   <= next_addr_hi;
		end
	end

	// output enable pin gates drivers without the clock
	assign dq_oe = {LANES{drive_q && !output_enable_n}};

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	logic              aw_hold;
	logic              w_hold;
	logic [AXI_AW-1:0] aw_addr;
	logic [DATA_W-1:0] w_data;
	logic [LANES-1:0]  w_strb;
	logic              next_aw_hold;
	logic              next_w_hold;
	logic [AXI_AW-1:0] next_aw_addr;
	logic [DATA_W-1:0] next_w_data;
	logic [LANES-1:0]  next_w_strb;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              next_rvalid;
	logic [DATA_W-1:0] next_rdata;
	logic [1:0]        next_rresp;
	logic              next_ctrl_sleep;
	logic [DATA_W-1:0] status_word;

	// true for offsets the slave answers
	function automatic logic reg_mapped(input logic [AXI_AW-1:0] a);
		reg_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_ADDR);
	endfunction : reg_mapped

	// channel state and register decode
	always_comb begin
		status_word                   = '0;
		status_word[STAT_LOW_LSB +: BURST_W] = burst_low;
		status_word[STAT_SLEEP_BIT]   = sleep_active;
		status_word[STAT_FLOW_BIT]    = mode.flow;
		status_word[STAT_LINEAR_BIT]  = mode.linear;
		status_word[STAT_DRIVE_BIT]   = drive_q;
		next_aw_hold    = aw_hold;
		next_w_hold     = w_hold;
		next_aw_addr    = aw_addr;
		next_w_data     = w_data;
		next_w_strb     = w_strb;
		next_bvalid     = s_axi_bvalid;
		next_bresp      = s_axi_bresp;
		next_ctrl_sleep = ctrl_sleep;
		next_rvalid     = s_axi_rvalid;
		next_rdata      = s_axi_rdata;
		next_rresp      = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_hold && w_hold && !s_axi_bvalid) begin
			next_aw_hold = 1'b0;
			next_w_hold  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = reg_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (aw_addr == REG_CTRL && w_strb[0]) begin
				next_ctrl_sleep = w_data[CTRL_SLEEP_BIT];
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			if (s_axi_araddr == REG_CTRL) begin
				next_rdata = DATA_W'(ctrl_sleep);
			end else if (s_axi_araddr == REG_STATUS) begin
				next_rdata = status_word;
			end else if (s_axi_araddr == REG_ADDR) begin
				next_rdata = DATA_W'({addr_hi, burst_low});
			end else begin
				next_rdata = '0;
			end
		end
	end

	// slave registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_hold       <= 1'b0;
			w_hold        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			ctrl_sleep    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			aw_hold       <= next_aw_hold;
			w_hold        <= next_w_hold;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			ctrl_sleep    <= next_ctrl_sleep;
			s_axi_awready <= !next_aw_hold && !next_bvalid;
			s_axi_wready  <= !next_w_hold && !next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_pipe_reads;
		(cyc.op == OP_READ && !mode.flow) ##1 (cyc.op == OP_READ && !mode.flow);
	endsequence

	a_lane_global_all: assert property (!global_store_n |-> lane_we == '1 && store_intent)
		else $error("global store did not enable all lanes");
	a_begin_load_start: assert property (cyc.src == SRC_EXT |=> burst_low == $past(low_addr_bits))
		else $error("begin burst did not load start");
	a_count_wrap: assert property (cyc.src == SRC_NEXT && burst_step == STEP_LAST |=> burst_step == STEP_ZERO)
		else $error("burst step did not wrap");
	a_linear_step_add: assert property (cyc.src == SRC_NEXT && mode.linear && $stable(mode.linear)
			|=> burst_low == BURST_W'($past(burst_low) + STEP_ONE))
		else $error("linear burst did not add one");
	a_write_floats: assert property (cyc.op == OP_WRITE |=> dq_oe == '0)
		else $error("data driven after write cycle");
	a_desel_floats: assert property (cyc.op == OP_DESEL |=> !drive_q)
		else $error("data driven after deselect");
	a_flow_read_now: assert property ((cyc.op == OP_READ && mode.flow) ##0 $stable(mode.flow)
			|=> drive_q && dq_out == $past(mem_rd))
		else $error("flow read data not shown next cycle");
	a_pipe_read_late: assert property (s_pipe_reads |=> drive_q && dq_out == $past(mem_rd, 2))
		else $error("pipelined read not one clock later");
	a_suspend_hold: assert property (cyc.src == SRC_CUR |=> $stable(burst_low) && $stable(addr_hi))
		else $error("suspend moved the address");
	a_oe_gate_off: assert property (output_enable_n |-> dq_oe == '0)
		else $error("drivers on with output enable high");
	a_sleep_no_store: assert property (sleep_active |-> cyc.op == OP_DESEL)
		else $error("array accessed while asleep");
	a_sleep_hold: assert property (sleep_active |=> $stable(burst_step) && $stable(addr_hi))
		else $error("burst address moved while asleep");
	a_dummy_advance: assert property (cyc.op == OP_READ && cyc.src == SRC_NEXT && output_enable_n
			|=> burst_step == BURST_W'($past(burst_step) + STEP_ONE))
		else $error("dummy read did not advance");

endmodule : sbs_sram_core

`default_nettype wire

// file: testbench/sbs_host_model.sv
// Purpose: host side model driving the burst sram pins
// Assumes: one request per clock, changed just after the edge
// Notes:   data lines carry inverted junk outside write cycles
`default_nettype none

module sbs_host_model (
	// clock
	input  wire logic        clk,
	// {oe_n, sel_hi, sel3_n, cs_n, proc_n, ctrl_n, step_n}
	output var  logic [6:0]  ctl,
	// {global_n, gate_n, lane d..a}
	output var  logic [5:0]  wr,
	// address and data
	output var  logic [1:0]  low,
	output var  logic [31:0] dq
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle as deselected host
	initial begin
		ctl = 7'h2d;
		wr  = 6'h3f;
		low = 2'h0;
		dq  = 32'h0;
	end

	// one sram cycle; host drives the strobes as given, so a load may use the processor or the ctrl strobe
	task automatic cyc(input logic [6:0] c, input logic [5:0] w, input logic [1:0] a,
		input logic [31:0] d);
		ctl <= c;
		wr  <= w;
		low <= a;
		dq  <= (!w[5] || (!w[4] && !(&w[3:0]))) ? d : ~dq; // given data on writes, inverted junk otherwise
		@(posedge clk);
		#1;
	endtask : cyc
endmodule : sbs_host_model

`default_nettype wire

// file: testbench/testbench.sv
// Purpose: self-checking bench of the burst sram control block
// Assumes: host model on the pins, axi4-lite master tasks here
// Notes:   flow, linear at start; modes switched by pins later
`default_nettype none

module testbench
	import sbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [6:0] DES = 7'h2d, BEGP = 7'h23, BEGC = 7'h25, STEP = 7'h26, HOLD = 7'h27;
	localparam logic [5:0] W_RD = 6'h3f, W_ALL = 6'h1f, W_LB = 6'h2d;
	logic        clk, rst_b, order, bypass, sleep;
	logic [6:0]  ctl;
	logic [5:0]  wr;
	logic [1:0]  low, bresp, rresp, r;
	logic [31:0] dq, dq_out, wdata, rdata, got;
	logic [31:0] mem [4];
	logic [3:0]  dq_oe, awaddr, araddr, wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          n_mismatch, comparisons, cycles;

	sbs_sram_core #(.ADDR_W(6)) u_sbs_sram_core (
		.clk(clk), .rst_b(rst_b), .burst_order_select(order),
		.output_bypass_select(bypass), .sleep_request(sleep),
		.chip_select_primary_n(ctl[3]), .select_high_active(ctl[5]),
		.select_low_third_n(ctl[4]), .proc_addr_strobe_n(ctl[2]),
		.ctrl_addr_strobe_n(ctl[1]), .burst_step_n(ctl[0]), .global_store_n(wr[5]),
		.byte_lane_gate_n(wr[4]), .lane_a_store_n(wr[0]), .lane_b_store_n(wr[1]),
		.lane_c_store_n(wr[2]), .lane_d_store_n(wr[3]), .output_enable_n(ctl[6]),
		.addr_high(4'h5), .low_addr_bits(low), .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	sbs_host_model u_sbs_host_model (.clk(clk), .ctl(ctl), .wr(wr), .low(low), .dq(dq));

	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// axi4-lite write; extra edge so strobes never toggle twice at once
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			r = bresp;
		end while (!bvalid);
		bready <= 1'b0;
		@(posedge clk);
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			got = rdata;
			r   = rresp;
		end while (!rvalid);
		rready <= 1'b0;
		@(posedge clk);
	endtask : axi_rd

	task automatic idle(input int n);
		repeat (n) u_sbs_host_model.cyc(DES, W_RD, 2'h0, 32'h0);
	endtask : idle

	task automatic t_regs;
		axi_rd(REG_STATUS);
		chk("mode bits", 32'(got[4:2]), 32'h6);
		axi_wr(REG_CTRL, 32'h1);
		chk("ctrl resp", 32'(r), 32'(RESP_OKAY));
		axi_rd(REG_CTRL);
		chk("ctrl read", got, 32'h1);
		axi_rd(REG_STATUS);
		chk("soft sleep", 32'(got[2]), 32'h1);
		axi_wr(REG_CTRL, 32'h0);
		axi_rd(4'hc);
		chk("unmapped resp", 32'(r), 32'(RESP_SLVERR));
	endtask : t_regs

	// burst write, lane write, then a write refused in sleep
	task automatic t_write;
		for (int i = 0; i < 4; i++) begin
			u_sbs_host_model.cyc(i == 0 ? BEGC : STEP, W_ALL, 2'h0, mem[i]);
			chk("write float", 32'(dq_oe), 32'h0);
		end
		u_sbs_host_model.cyc(BEGC, W_LB, 2'h1, 32'h0000ab00);
		mem[1][15:8] = 8'hab;
		chk("lane float", 32'(dq_oe), 32'h0);
		sleep <= 1'b1;
		idle(3);
		u_sbs_host_model.cyc(BEGC, W_ALL, 2'h2, 32'hdead0000);
		sleep <= 1'b0;
		idle(3);
	endtask : t_write

	task automatic t_lin;
		logic [1:0]  a;
		logic [6:0]  ds [4];
		a  = 2'h2;
		ds = '{7'h2d, 7'h03, 7'h05, 7'h33};
		u_sbs_host_model.cyc(BEGP, W_RD, a, 32'h0);
		for (int i = 0; i < 5; i++) begin
			chk("linear data", dq_out, mem[a]);
			chk("read lanes", 32'(dq_oe), 32'hf);
			a = a + 2'h1;
			u_sbs_host_model.cyc(STEP, W_RD, 2'h0, 32'h0);
		end
		u_sbs_host_model.cyc(HOLD, W_RD, 2'h0, 32'h0);
		chk("hold data", dq_out, mem[a]);
		u_sbs_host_model.cyc(HOLD | 7'h40, W_RD, 2'h0, 32'h0);
		chk("oe gate", 32'(dq_oe), 32'h0);
		foreach (ds[k]) begin
			u_sbs_host_model.cyc(BEGP, W_RD, 2'h0, 32'h0);
			u_sbs_host_model.cyc(ds[k], W_RD, 2'h0, 32'h0);
			chk("deselect float", 32'(dq_oe), 32'h0);
		end
		// dummy read with output enable high must still step the counter
		u_sbs_host_model.cyc(BEGP, W_RD, 2'h0, 32'h0);
		u_sbs_host_model.cyc(STEP | 7'h40, W_RD, 2'h0, 32'h0);
		u_sbs_host_model.cyc(STEP, W_RD, 2'h0, 32'h0);
		chk("dummy advance", dq_out, mem[2]);
	endtask : t_lin

	task automatic t_inter;
		order <= 1'b1;
		idle(3);
		u_sbs_host_model.cyc(BEGC, W_RD, 2'h1, 32'h0);
		for (int i = 0; i < 5; i++) begin
			chk("interleaved data", dq_out, mem[2'h1 ^ 2'(i)]);
			u_sbs_host_model.cyc(STEP, W_RD, 2'h0, 32'h0);
		end
	endtask : t_inter

	task automatic t_pipe;
		bypass <= 1'b1;
		idle(3);
		u_sbs_host_model.cyc(BEGP, W_RD, 2'h0, 32'h0);
		u_sbs_host_model.cyc(STEP, W_RD, 2'h0, 32'h0);
		chk("pipe first", dq_out, mem[0]);
		u_sbs_host_model.cyc(STEP, W_RD, 2'h0, 32'h0);
		chk("pipe second", dq_out, mem[1]);
	endtask : t_pipe

	initial begin
		rst_b   = 1'b0;
		order   = 1'b0;
		bypass  = 1'b0;
		sleep   = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, wstrb} = {8'h0, 32'h0, 4'hf};
		{n_mismatch, comparisons, cycles} = '0;
		foreach (mem[i]) mem[i] = 32'h5a3c0000 + 32'(i * 257 + 17);
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_write();
		t_lin();
		t_inter();
		t_pipe();
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
